/* File: design/flag_bank.sv */
// bank of sticky flags, set by hardware, cleared by software
`default_nettype none
module flag_bank
  import irq_flags_pkg::*;
#(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  // set and clear strobes
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // flag state
  output logic      [W-1:0] q_o
);
  logic [W-1:0] flag_q, flag_d; // flag state

  // set beats clear so a coincident event survives
  always_comb
  begin
    flag_d = set_i | (flag_q & ~clr_i);
  end

  // registers
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      flag_q <= RST;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  assign q_o = flag_q;
endmodule : flag_bank
`default_nettype wire

/* File: design/interrupt_request_flags.sv */
// request flag registers with an axi4-lite register slave
`default_nettype none
// What this block does
// - event counter enable gates its requests
// - first register latches timer and pins
// - interrupt acceptance never clears flags
// - writing one never sets a flag
// - writing zero clears a set flag
// - interval flag sets on counter wrap
// - first register bit six plain storage
// - first register bit five reads one
// - pin flags set on selected edge
// - direct flag sets on enabled sleep
// - converter flag sets when busy falls
// - second register bit five plain storage
// - capture flag on edge or enabled overflow
// - compare high flag on mode match
// - compare low flag in 8-bit mode
// - reload flag on overflow or underflow
// - event flag on counter overflow by mode
// - flags pass to the outputs without enable masking
module interrupt_request_flags
  import irq_flags_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // axi4-lite write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  // axi4-lite read
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [3:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // peripheral sources, same clock
  input  wire counters_t   cnt_i,
  input  wire periph_t     periph_i,
  // external pins, asynchronous
  input  wire logic [4:0]  ext_request_pin_n_i,
  input  wire logic [4:0]  ext_pin_sel_i,
  input  wire logic [4:0]  ext_rise_sel_i,
  input  wire logic        capture_input_pin_i,
  // flags toward the cpu arbitration
  output logic [7:0]       request_flags_one_o,
  output logic [7:0]       request_flags_two_o,
  output logic             evcnt_int_enable_o
);
  // write path state
  logic        aw_held_q, aw_held_d;   // address waiting
  logic [3:0]  aw_addr_q, aw_addr_d;   // latched address
  logic        w_held_q,  w_held_d;    // data waiting
  logic [7:0]  w_data_q,  w_data_d;    // low byte of data
  logic        w_lane_q,  w_lane_d;    // low byte strobe
  logic        bvalid_q,  bvalid_d;    // response pending
  logic [1:0]  bresp_q,   bresp_d;     // response code
  logic        wr_fire;                // write takes effect
  logic        wr_mapped;              // address decodes
  // read path state
  logic        rvalid_q,  rvalid_d;    // read data pending
  logic [31:0] rdata_q,   rdata_d;     // read data word
  logic [1:0]  rresp_q,   rresp_d;     // read response
  logic        rd_fire;                // read address taken
  // software-visible storage
  logic        spare_one_q, spare_one_d; // first reg bit 6
  logic        spare_two_q, spare_two_d; // second reg bit 5
  logic        ev_en_q,     ev_en_d;     // evcnt_int_enable
  // previous samples for edge and wrap detection
  counters_t   prev_q;                 // counters last cycle
  logic        conv_prev_q;            // busy last cycle
  logic        prev_ok_q;              // prev_q holds a real sample
  // flag strobes and state
  logic [7:0]  set_one, clr_one;       // first register
  logic [7:0]  set_two, clr_two;       // second register
  logic [7:0]  flags_one_q;            // first register flags
  logic [7:0]  flags_two_q;            // second register flags
  logic [7:0]  rd_one, rd_two, rd_en;  // read views
  logic [4:0]  ext_pulse;              // pin edge pulses
  logic        cap_pulse;              // capture pin edge
  logic        hi_eq, lo_eq;           // compare equality now
  logic        hi_eq_prev, lo_eq_prev; // equality last cycle

  // pins come in asynchronously; the low-active name is just the pin
  pin_edge_detect #(.W(NUM_EXT_PINS)) u_ext_pins (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (ext_request_pin_n_i),
    .sel_i      (ext_pin_sel_i),
    .rise_i     (ext_rise_sel_i),
    .pulse_o    (ext_pulse)
  );

  // capture pin has its own edge select
  pin_edge_detect #(.W(1)) u_cap_pin (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .pin_i      (capture_input_pin_i),
    .sel_i      (periph_i.cap_pin_sel),
    .rise_i     (periph_i.cap_rise),
    .pulse_o    (cap_pulse)
  );

  // write waits until both halves are held and no reply pends
  assign wr_fire   = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_mapped = (aw_addr_q == OFS_FLAGS_ONE) |
                     (aw_addr_q == OFS_FLAGS_TWO) |
                     (aw_addr_q == OFS_ENABLE_TWO);
  assign rd_fire   = s_axi_arvalid_i & ~rvalid_q;

  // write channel next state: address and data in either order
  always_comb
  begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid_i && !aw_held_q)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_held_q)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata_i[7:0];
      w_lane_d = s_axi_wstrb_i[0];
    end
    if (wr_fire)
    begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready_i)
    begin
      bvalid_d = 1'b0;
    end
  end

  // clear masks: zero bits clear flags, one bits do nothing
  always_comb
  begin
    clr_one = '0;
    clr_two = '0;
    if (wr_fire && w_lane_q && aw_addr_q == OFS_FLAGS_ONE)
    begin
      clr_one = ~w_data_q & FLAGS_ONE_MASK;
    end
    if (wr_fire && w_lane_q && aw_addr_q == OFS_FLAGS_TWO)
    begin
      clr_two = ~w_data_q & FLAGS_TWO_MASK;
    end
  end

  // plain storage bits take the written value
  always_comb
  begin
    spare_one_d = spare_one_q;
    spare_two_d = spare_two_q;
    ev_en_d     = ev_en_q;
    if (wr_fire && w_lane_q)
    begin
      case (aw_addr_q)
        OFS_FLAGS_ONE:  spare_one_d = w_data_q[BIT_ONE_SPARE];
        OFS_FLAGS_TWO:  spare_two_d = w_data_q[BIT_TWO_SPARE];
        OFS_ENABLE_TWO: ev_en_d     = w_data_q[BIT_EVCNT_EN];
        default:        ev_en_d     = ev_en_q;
      endcase
    end
  end

  // compare equality now and one cycle ago; a match is the rise
  assign hi_eq      = cnt_i.cmp_cnt_hi == cnt_i.cmp_val_hi;
  assign lo_eq      = cnt_i.cmp_cnt_lo == cnt_i.cmp_val_lo;
  assign hi_eq_prev = prev_q.cmp_cnt_hi == prev_q.cmp_val_hi;
  assign lo_eq_prev = prev_q.cmp_cnt_lo == prev_q.cmp_val_lo;

  // set strobes; sleep, capture overflow and event wraps are gated here by their enables
  always_comb
  begin
    set_one = '0;
    set_two = '0;
    set_one[BIT_INTERVAL] = prev_q.interval == CNT_MAX &&
                            cnt_i.interval == CNT_ZERO;
    set_one[4:0] = ext_pulse;
    set_two[BIT_DIRECT] = periph_i.sleep_exec &
                          periph_i.direct_xfer_on;
    set_two[BIT_CONVERTER] = conv_prev_q &
                             ~periph_i.conv_running;
    set_two[BIT_CAPTURE] = cap_pulse |
      (periph_i.cap_overflow & periph_i.ovf_int_en);
    if (periph_i.cmp_mode16)
    begin
      set_two[BIT_CMP_HI] = hi_eq & lo_eq &
                            ~(hi_eq_prev & lo_eq_prev);
    end
    else
    begin
      set_two[BIT_CMP_HI] = hi_eq & ~hi_eq_prev;
      set_two[BIT_CMP_LO] = lo_eq & ~lo_eq_prev;
    end
    set_two[BIT_RELOAD] =
      (prev_q.reload == CNT_MAX && cnt_i.reload == CNT_ZERO) ||
      (prev_q.reload == CNT_ZERO && cnt_i.reload == CNT_MAX);
    if (periph_i.ev_mode16)
    begin
      set_two[BIT_EVCNT] = prev_q.ev_hi == CNT_MAX &&
                           cnt_i.ev_hi == CNT_ZERO;
    end
    else
    begin
      set_two[BIT_EVCNT] =
        (prev_q.ev_hi == CNT_MAX && cnt_i.ev_hi == CNT_ZERO) ||
        (prev_q.ev_lo == CNT_MAX && cnt_i.ev_lo == CNT_ZERO);
    end
    set_two[BIT_EVCNT] = set_two[BIT_EVCNT] & ev_en_q;
    // first cycle after reset compares against the reset zeros, so a
    // counter parked at its top would look like an underflow
    if (!prev_ok_q)
    begin
      set_one[BIT_INTERVAL] = 1'b0;
      set_two[BIT_CMP_HI]   = 1'b0;
      set_two[BIT_CMP_LO]   = 1'b0;
      set_two[BIT_RELOAD]   = 1'b0;
      set_two[BIT_EVCNT]    = 1'b0;
    end
  end

  // first register; bit 5 never set nor cleared, holds its one
  flag_bank #(.W(8), .RST(FLAGS_ONE_RST)) u_flags_one (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .set_i      (set_one),
    .clr_i      (clr_one),
    .q_o        (flags_one_q)
  );

  // second register
  flag_bank #(.W(8), .RST(FLAGS_TWO_RST)) u_flags_two (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .set_i      (set_two),
    .clr_i      (clr_two),
    .q_o        (flags_two_q)
  );

  // read views merge plain storage into the flag words
  always_comb
  begin
    rd_one = flags_one_q;
    rd_one[BIT_ONE_SPARE] = spare_one_q;
    rd_two = flags_two_q;
    rd_two[BIT_TWO_SPARE] = spare_two_q;
    rd_en = ENABLE_TWO_RST;
    rd_en[BIT_EVCNT_EN] = ev_en_q;
  end

  // read channel: one read at a time, data from flops
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rd_fire)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (s_axi_araddr_i)
        OFS_FLAGS_ONE:  rdata_d = {24'h000000, rd_one};
        OFS_FLAGS_TWO:  rdata_d = {24'h000000, rd_two};
        OFS_ENABLE_TWO: rdata_d = {24'h000000, rd_en};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready_i)
    begin
      rvalid_d = 1'b0;
    end
  end

  // registers of the slave and of the storage bits
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      aw_held_q   <= 1'b0;
      aw_addr_q   <= 4'h0;
      w_held_q    <= 1'b0;
      w_data_q    <= 8'h00;
      w_lane_q    <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h00000000;
      rresp_q     <= RESP_OKAY;
      spare_one_q <= FLAGS_ONE_RST[BIT_ONE_SPARE];
      spare_two_q <= FLAGS_TWO_RST[BIT_TWO_SPARE];
      ev_en_q     <= ENABLE_TWO_RST[BIT_EVCNT_EN];
      prev_q      <= '0;
      conv_prev_q <= 1'b0;
      prev_ok_q   <= 1'b0;
    end
    else
    begin
      aw_held_q   <= aw_held_d;
      aw_addr_q   <= aw_addr_d;
      w_held_q    <= w_held_d;
      w_data_q    <= w_data_d;
      w_lane_q    <= w_lane_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      spare_one_q <= spare_one_d;
      spare_two_q <= spare_two_d;
      ev_en_q     <= ev_en_d;
      prev_q      <= cnt_i;
      conv_prev_q <= periph_i.conv_running;
      prev_ok_q   <= 1'b1;
    end
  end

  // port drives
  assign s_axi_awready_o     = ~aw_held_q;
  assign s_axi_wready_o      = ~w_held_q;
  assign s_axi_bvalid_o      = bvalid_q;
  assign s_axi_bresp_o       = bresp_q;
  assign s_axi_arready_o     = ~rvalid_q;
  assign s_axi_rvalid_o      = rvalid_q;
  assign s_axi_rdata_o       = rdata_q;
  assign s_axi_rresp_o       = rresp_q;
  assign request_flags_one_o = rd_one;
  assign request_flags_two_o = rd_two;
  assign evcnt_int_enable_o  = ev_en_q;

  // checks on the flag behaviour
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  a_flags_sticky:
    assert property ((flags_two_q & $past(flags_two_q & ~clr_two))
                     == $past(flags_two_q & ~clr_two))
    else $error("flag dropped without a clearing write");
  a_no_sw_set:
    assert property (((flags_one_q & ~$past(flags_one_q))
                      & ~$past(set_one)) == 8'h00)
    else $error("flag rose without a set event");
  a_zero_clears:
    assert property ((clr_one != 8'h00) |=>
                     ((flags_one_q & $past(clr_one & ~set_one)) == 8'h00))
    else $error("written zero did not clear the flag");
  a_fixed_one:
    assert property (rd_one[BIT_ONE_FIXED] && flags_one_q[BIT_ONE_FIXED])
    else $error("first register bit five not one");
  a_interval_wrap:
    assert property ((prev_q.interval == CNT_MAX &&
                      cnt_i.interval == CNT_ZERO)
                     |=> flags_one_q[BIT_INTERVAL])
    else $error("interval wrap did not set its flag");
  a_evcnt_gated:
    assert property ((!ev_en_q && !flags_two_q[BIT_EVCNT])
                     |=> !flags_two_q[BIT_EVCNT])
    else $error("event flag set while disabled");
  a_conv_done:
    assert property ($fell(periph_i.conv_running) |=>
                     flags_two_q[BIT_CONVERTER])
    else $error("converter finish did not set its flag");
  a_lo_mode16:
    assert property ((periph_i.cmp_mode16 && !flags_two_q[BIT_CMP_LO])
                     |=> !flags_two_q[BIT_CMP_LO])
    else $error("low compare flag set in 16-bit mode");
  a_reset_view:
    assert property ($past(srst_i) |->
                     (rd_one == FLAGS_ONE_RST && rd_two == FLAGS_TWO_RST))
    else $error("register view wrong after reset");
  a_set_wins:
    assert property ((set_two & clr_two) != 8'h00 |=>
                     ((flags_two_q & $past(set_two & clr_two))
                      == $past(set_two & clr_two)))
    else $error("coincident clear beat a set");

  c_clear_write:
    cover property (clr_one != 8'h00 ##1 flags_one_q[BIT_INTERVAL] == 1'b0);
  c_pin_flag:
    cover property (ext_pulse != 5'h00 ##1 flags_one_q[4:0] != 5'h00);
  c_evcnt_flag:
    cover property (ev_en_q ##1 flags_two_q[BIT_EVCNT]);
  c_read_done:
    cover property (rvalid_q && s_axi_rready_i);
endmodule : interrupt_request_flags
`default_nettype wire

/* File: design/irq_flags_pkg.sv */
// shared constants and carriers for the request flag block
`default_nettype none
package irq_flags_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] OFS_FLAGS_ONE  = 4'h0;
  localparam logic [3:0] OFS_FLAGS_TWO  = 4'h4;
  localparam logic [3:0] OFS_ENABLE_TWO = 4'h8;
  // first register bit positions
  localparam int BIT_INTERVAL  = 7;
  localparam int BIT_ONE_SPARE = 6;
  localparam int BIT_ONE_FIXED = 5;
  localparam int NUM_EXT_PINS  = 5;
  // second register bit positions
  localparam int BIT_DIRECT    = 7;
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_TWO_SPARE = 5;
  localparam int BIT_CAPTURE   = 4;
  localparam int BIT_CMP_HI    = 3;
  localparam int BIT_CMP_LO    = 2;
  localparam int BIT_RELOAD    = 1;
  localparam int BIT_EVCNT     = 0;
  // enable register bit position
  localparam int BIT_EVCNT_EN  = 0;
  // reset values
  localparam logic [7:0] FLAGS_ONE_RST  = 8'h20;
  localparam logic [7:0] FLAGS_TWO_RST  = 8'h00;
  localparam logic [7:0] ENABLE_TWO_RST = 8'h00;
  // bits that behave as clear-only flags
  localparam logic [7:0] FLAGS_ONE_MASK = 8'h9F;
  localparam logic [7:0] FLAGS_TWO_MASK = 8'hDF;
  // counter wrap points
  localparam logic [7:0] CNT_MAX  = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // live counter values from the timers, same clock
  typedef struct packed {
    logic [7:0] interval;   // interval timer counter
    logic [7:0] reload;     // reload timer counter
    logic [7:0] ev_hi;      // event_counter_hi
    logic [7:0] ev_lo;      // event_counter_lo
    logic [7:0] cmp_cnt_hi; // compare_counter_hi
    logic [7:0] cmp_cnt_lo; // compare_counter_lo
    logic [7:0] cmp_val_hi; // compare_value_hi
    logic [7:0] cmp_val_lo; // compare_value_lo
  } counters_t;

  // peripheral status and control levels, same clock
  typedef struct packed {
    logic cmp_mode16;     // compare timer in 16-bit mode
    logic ev_mode16;      // event counter in 16-bit mode
    logic direct_xfer_on; // direct transfer enable
    logic sleep_exec;     // one-cycle pulse: sleep executed
    logic conv_running;   // converter busy level
    logic cap_overflow;   // one-cycle pulse: capture_counter wrap
    logic ovf_int_en;     // overflow_int_enable
    logic cap_pin_sel;    // capture pin set for capture
    logic cap_rise;       // capture on rising edge when 1
  } periph_t;
endpackage : irq_flags_pkg
`default_nettype wire

/* File: design/pin_edge_detect.sv */
// pin synchroniser with selectable edge detection
`default_nettype none
module pin_edge_detect
  import irq_flags_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  // pins and their configuration
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] sel_i,
  input  wire logic [W-1:0] rise_i,
  // one-cycle edge pulses
  output logic      [W-1:0] pulse_o
);
  logic [W-1:0] sync1_q, sync1_d; // first stage, read only by second
  logic [W-1:0] sync2_q, sync2_d; // settled pin level
  logic [W-1:0] last_q,  last_d;  // level one cycle earlier
  logic [W-1:0] pulse_q, pulse_d; // registered edge pulse

  // next values: edge is judged only between settled stages
  always_comb
  begin
    sync1_d = pin_i;
    sync2_d = sync1_q;
    last_d  = sync2_q;
    pulse_d = sel_i & ((rise_i & sync2_q & ~last_q) |
                       (~rise_i & ~sync2_q & last_q));
  end

  // registers; pins idle high after reset, so no false fall
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
      last_q  <= '1;
      pulse_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      last_q  <= last_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse_o = pulse_q;
endmodule : pin_edge_detect
`default_nettype wire

/* File: verification/periph_model.sv */
// peripheral event sources and request pins facing the flag block
`default_nettype none
module periph_model
  import irq_flags_pkg::*;
(
  // clock
  input  wire logic  core_clk_i,
  // sources toward the flag block
  output var counters_t cnt_o,
  output var periph_t   per_o,
  output logic [4:0] pin_o,
  output logic       cap_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // counters sit at their wrap points so one step wraps them
  initial
  begin
    cnt_o     = 64'hFF00FFFF00005566;
    per_o     = '0;
    pin_o     = 5'h1F; // pins idle high
    cap_pin_o = 1'b1;
  end

  // one step per clock; pulses last exactly one cycle
  task automatic drive(input counters_t c, input periph_t p);
    @(posedge core_clk_i);
    cnt_o <= c;
    per_o <= p;
    @(posedge core_clk_i);
    per_o.sleep_exec   <= 1'b0;
    per_o.cap_overflow <= 1'b0;
  endtask : drive

  // pin levels change only just after an edge
  task automatic pins(input logic [4:0] v, input logic cp);
    @(posedge core_clk_i);
    pin_o     <= v;
    cap_pin_o <= cp;
  endtask : pins
endmodule : periph_model
`default_nettype wire

/* File: verification/test_interrupt_request_flags.sv */
// register and event tests for the request flag block
`default_nettype none
module test_interrupt_request_flags
  import irq_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic        arv = 1'b0, rready = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [4:0]  sel = 5'h00, rise = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid, en;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  f1, f2, e;
  counters_t   cnt, c;
  periph_t     per, p;
  logic [4:0]  pins;
  logic        cap;
  int          compares = 0, miscompares = 0, k;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  interrupt_request_flags DUT (
    .core_clk_i(clk), .srst_i(srst),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .cnt_i(cnt), .periph_i(per),
    .ext_request_pin_n_i(pins), .ext_pin_sel_i(sel),
    .ext_rise_sel_i(rise), .capture_input_pin_i(cap),
    .request_flags_one_o(f1), .request_flags_two_o(f2),
    .evcnt_int_enable_o(en)
  );

  periph_model PRT (
    .core_clk_i(clk), .cnt_o(cnt), .per_o(per),
    .pin_o(pins), .cap_pin_o(cap)
  );

  // counts, verdict and end of run
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // four-state comparison of one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a hung handshake counts as a mismatch and ends the run
  task automatic hang();
    miscompares++;
    wrap_up();
  endtask : hang

  // axi4-lite write; address and data released as each is taken
  task automatic wrc(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata  <= {24'h0, d};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (awready)
        awv <= 1'b0;
      if (wready)
        wv <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (n == 40)
      hang();
    chk({30'h0, bresp}, {30'h0, r});
  endtask : wrc

  // axi4-lite read with data and response compared
  task automatic rdc(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (arready)
        arv <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (n == 40)
      hang();
    chk(rdata, {24'h0, d});
    chk({30'h0, rresp}, {30'h0, r});
  endtask : rdc

  // apply one source step, then look at the second register
  task automatic ev(input logic [7:0] x);
    PRT.drive(c, p);
    p.sleep_exec   = 1'b0;
    p.cap_overflow = 1'b0;
    repeat (3) @(posedge clk);
    chk({24'h0, f2}, {24'h0, x});
  endtask : ev

  // pin change, then time for the synchroniser
  task automatic pstep(input logic [4:0] v, input logic cp);
    PRT.pins(v, cp);
    repeat (8) @(posedge clk);
  endtask : pstep

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    c = PRT.cnt_o;
    p = PRT.per_o;
    rdc(OFS_FLAGS_ONE, 8'h20, RESP_OKAY);
    rdc(OFS_FLAGS_TWO, 8'h00, RESP_OKAY);
    rdc(OFS_ENABLE_TWO, 8'h00, RESP_OKAY);
    rdc(4'hC, 8'h00, RESP_SLVERR);
    wrc(4'hC, 8'hFF, RESP_SLVERR);
    $display("test reset done");
    // ones written: only the storage bits take them
    wrc(OFS_FLAGS_ONE, 8'hFF, RESP_OKAY);
    rdc(OFS_FLAGS_ONE, 8'h60, RESP_OKAY);
    wrc(OFS_FLAGS_TWO, 8'hFF, RESP_OKAY);
    rdc(OFS_FLAGS_TWO, 8'h20, RESP_OKAY);
    wrc(OFS_FLAGS_ONE, 8'h00, RESP_OKAY);
    wrc(OFS_FLAGS_TWO, 8'h00, RESP_OKAY);
    rdc(OFS_FLAGS_ONE, 8'h20, RESP_OKAY);
    rdc(OFS_FLAGS_TWO, 8'h00, RESP_OKAY);
    $display("test storage done");
    // interval counter wraps from top to zero
    c.interval = 8'h00;
    ev(8'h00);
    chk({24'h0, f1}, 32'hA0);
    repeat (20) @(posedge clk);
    chk({24'h0, f1}, 32'hA0);
    wrc(OFS_FLAGS_ONE, 8'h1F, RESP_OKAY);
    rdc(OFS_FLAGS_ONE, 8'h20, RESP_OKAY);
    $display("test interval done");
    // pins not configured give nothing, then each edge kind
    pstep(5'h00, 1'b1);
    pstep(5'h1F, 1'b1);
    chk({24'h0, f1}, 32'h20);
    e = 8'h20;
    for (k = 0; k < 5; k++)
    begin
      sel     <= sel | (5'h01 << k);
      rise[k] <= k[0];
      pstep(~(5'h01 << k), 1'b1);
      pstep(5'h1F, 1'b1);
      e[k] = 1'b1;
      chk({24'h0, f1}, {24'h0, e});
    end
    wrc(OFS_FLAGS_ONE, 8'h00, RESP_OKAY);
    rdc(OFS_FLAGS_ONE, 8'h20, RESP_OKAY);
    $display("test pins done");
    // second register sources, each gated case first
    p.sleep_exec = 1'b1;
    ev(8'h00);
    p.direct_xfer_on = 1'b1;
    p.sleep_exec = 1'b1;
    ev(8'h80);
    p.conv_running = 1'b1;
    ev(8'h80);
    p.conv_running = 1'b0;
    ev(8'hC0);
    p.cap_overflow = 1'b1;
    ev(8'hC0);
    p.ovf_int_en = 1'b1;
    p.cap_overflow = 1'b1;
    ev(8'hD0);
    c.cmp_cnt_hi = 8'h55;
    ev(8'hD8);
    c.cmp_cnt_lo = 8'h66;
    ev(8'hDC);
    c.reload = 8'hFF;
    ev(8'hDE);
    c.ev_lo = 8'h00;
    ev(8'hDE);
    wrc(OFS_ENABLE_TWO, 8'hFF, RESP_OKAY);
    rdc(OFS_ENABLE_TWO, 8'h01, RESP_OKAY);
    chk({31'h0, en}, 32'h1);
    c.ev_hi = 8'h00;
    ev(8'hDF);
    $display("test sources done");
    // capture pin edge and 16-bit compare
    wrc(OFS_FLAGS_TWO, 8'hC3, RESP_OKAY);
    c.cmp_cnt_hi = 8'h00;
    p.cmp_mode16 = 1'b1;
    p.cap_pin_sel = 1'b1;
    ev(8'hC3);
    pstep(5'h1F, 1'b0);
    chk({24'h0, f2}, 32'hD3);
    c.cmp_cnt_hi = 8'h55;
    ev(8'hDB);
    // reload overflow lands in the cycle the clearing write fires
    c.reload = 8'h00;
    fork
      wrc(OFS_FLAGS_TWO, 8'h00, RESP_OKAY);
      begin
        @(posedge clk);
        PRT.drive(c, p);
      end
    join
    rdc(OFS_FLAGS_TWO, 8'h02, RESP_OKAY);
    wrc(OFS_FLAGS_TWO, 8'h00, RESP_OKAY);
    rdc(OFS_FLAGS_TWO, 8'h00, RESP_OKAY);
    $display("test compare done");
    wrap_up();
  end
endmodule : test_interrupt_request_flags
`default_nettype wire
